// File: src/qrvs_core.sv
// valley switch timing core: soft-start, valley select, crossing count, gate timing
//
// Notes on behaviour
// R1: above supply turn-on, stop charging cell and start switching via soft-start.
// R2: soft-start lasts 12 ms in four equal steps.
// R3: current ceiling steps from 0.32 V up to 1 V.
// R4: valley select sets the crossing index at which the gate turns on.
// R5: feedback compared over 48 ms periods; counter updated at period end.
// R6: always below count-up threshold: increment, stop at 7.
// R7: above count-up but never count-down threshold: hold.
// R8: above count-down but never reset threshold: decrement, stop at 1.
// R9: above reset threshold at any time: force counter to 1.
// R10: valley counter stays 1..7, out-of-range steps ignored.
// R11: valley counter starts at 1.
// R12: line level selects which count-up/count-down threshold pair is used.
// R13: crossing counter spans 0 to 7.
// R14: each falling crossing of 100 mV after turn-off adds one.
// R15: crossing counter cleared whenever the gate goes high.
// R16: overvoltage during off-time latches off after blanking interval.
// R17: ring timer long when sense below ring-select threshold, else short.
// R18: gate on after ring time once crossings reach valley select, never before.
// R19: gate on after max off period regardless.
// R20: gate stays high for at least leading-edge blank time.
// R21: leaving burst mode forces valley counter to 1.
// R22: comparators synchronised; falling crossings are edges of synced signal.
// R23: sticky threshold flags per period, cleared at each new period.
`timescale 1ns/1ps
module qrvs_core #(
    parameter int SS_STEP_CYC = qrvs_pkg::SS_STEP_CYCLES,
    parameter int EVAL_CYC = qrvs_pkg::EVAL_CYCLES,
    parameter int RING_LONG_CYC = qrvs_pkg::RING_LONG_CYCLES,
    parameter int RING_SHORT_CYC = qrvs_pkg::RING_SHORT_CYCLES,
    parameter int MAX_OFF_CYC = qrvs_pkg::MAX_OFF_CYCLES,
    parameter int LEB_CYC = qrvs_pkg::LEB_CYCLES,
    parameter int OVP_BLANK_CYC = qrvs_pkg::OVP_BLANK_CYCLES
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic supply_on_i,       // supply above supply_turn_on_threshold
    input wire logic fb_up_lo_i,        // feedback above count-up threshold, low line pair
    input wire logic fb_up_hi_i,        // feedback above count-up threshold, high line pair
    input wire logic fb_dn_lo_i,        // feedback above count-down threshold, low line pair
    input wire logic fb_dn_hi_i,        // feedback above count-down threshold, high line pair
    input wire logic fb_rst_i,          // feedback above counter reset threshold
    input wire logic line_high_i,       // sensed line level is high
    input wire logic cross_i,           // crossing sense above 100 mV
    input wire logic cross_ovp_i,       // crossing sense above overvoltage threshold
    input wire logic cross_ring_i,      // crossing sense above ring-select threshold
    input wire logic cur_trip_i,        // current comparator asks turn-off
    input wire logic burst_exit_i,      // pulse: leaving burst mode
    output logic charge_en_o,
    output logic gate_o,
    output logic latched_off_o,
    output logic soft_done_o,
    output logic [9:0] ceiling_mv_o,
    output logic [2:0] valley_o,
    output logic [2:0] cross_cnt_o
);
    localparam int TW = qrvs_pkg::TMR_W;

    typedef enum logic [1:0] {
        QRVS_IDLE = 2'b00,
        QRVS_ON = 2'b01,
        QRVS_OFF = 2'b10,
        QRVS_LATCH = 2'b11
    } qrvs_state_t;

    // ring window length for the chosen preset, shared by the timer and its check
    function automatic logic [TW-1:0] ring_len(input logic long_sel);
        ring_len = long_sel ? TW'(RING_LONG_CYC) : TW'(RING_SHORT_CYC);
    endfunction : ring_len

    // =====================================================================
    // comparator synchronisation
    // line level travels with the pairs, so a line change never mixes old and new pair readings
    logic [11:0] sy;
    qrvs_sync #(.W(12)) u_sync (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .async_i({line_high_i, burst_exit_i, cur_trip_i, cross_ring_i, cross_ovp_i, cross_i,
                  fb_rst_i, fb_dn_hi_i, fb_dn_lo_i, fb_up_hi_i, fb_up_lo_i, supply_on_i}),
        .sync_o(sy) // R22
    );
    logic s_sup, s_dn, s_rst, s_cross, s_ovp, s_ring, s_trip, s_bexit;
    assign s_sup = sy[0];
    assign s_rst = sy[5];
    assign s_cross = sy[6];
    assign s_ovp = sy[7];
    assign s_ring = sy[8];
    assign s_trip = sy[9];
    assign s_bexit = sy[10];
    // pair selection by line level
    logic s_up_sel, s_dn_sel;
    assign s_up_sel = sy[11] ? sy[2] : sy[1]; // R12
    assign s_dn_sel = sy[11] ? sy[4] : sy[3]; // R12
    assign s_dn = s_dn_sel;

    // =====================================================================
    // state registers
    qrvs_state_t st_reg, st_next;
    logic [TW-1:0] tmr_reg, tmr_next;      // on or off time
    logic [TW-1:0] ss_reg, ss_next;        // soft-start step timer
    logic [1:0] step_reg, step_next;
    logic ss_done_reg, ss_done_next;
    logic [TW-1:0] ev_reg, ev_next;
    logic up_seen_reg, up_seen_next, dn_seen_reg, dn_seen_next, rs_seen_reg, rs_seen_next;
    logic [2:0] val_reg, val_next;
    logic [2:0] zc_reg, zc_next;
    logic cross_d_reg, cross_d_next;
    logic [TW-1:0] ring_reg, ring_next;
    logic ring_long_reg, ring_long_next;
    logic [TW-1:0] ovp_reg, ovp_next;
    logic gate_reg, gate_next, chg_reg, chg_next, lat_reg, lat_next;
    logic [9:0] ceil_reg, ceil_next;

    // =====================================================================
    // next state: one process for the whole timing core
    always_comb begin
        logic run;
        logic fall;
        logic ev_end;
        run = 1'b0;
        fall = 1'b0;
        ev_end = 1'b0;
        st_next = st_reg;
        tmr_next = tmr_reg;
        ss_next = ss_reg;
        step_next = step_reg;
        ss_done_next = ss_done_reg;
        ev_next = ev_reg;
        up_seen_next = up_seen_reg;
        dn_seen_next = dn_seen_reg;
        rs_seen_next = rs_seen_reg;
        val_next = val_reg;
        zc_next = zc_reg;
        cross_d_next = s_cross;
        ring_next = ring_reg;
        ring_long_next = ring_long_reg;
        ovp_next = ovp_reg;
        gate_next = gate_reg;
        chg_next = chg_reg;
        lat_next = lat_reg;
        ceil_next = ceil_reg;
        run = (st_reg == QRVS_ON) || (st_reg == QRVS_OFF);
        fall = cross_d_reg && !s_cross; // R22
        // soft-start stepping, time based only
        if (run && !ss_done_reg) begin
            if (ss_reg == TW'(SS_STEP_CYC - 1)) begin // R2
                ss_next = '0;
                if (step_reg == 2'(qrvs_pkg::SS_STEPS - 1)) begin
                    ss_done_next = 1'b1;
                end else begin
                    step_next = step_reg + 2'h1;
                    ceil_next = (step_reg == 2'(qrvs_pkg::SS_STEPS - 2)) ? qrvs_pkg::CEIL_LAST_MV
                                : ceil_reg + qrvs_pkg::CEIL_STEP_MV; // R3
                end
            end else begin
                ss_next = ss_reg + TW'(1);
            end
        end
        // evaluation period with sticky flags
        if (run) begin
            ev_end = (ev_reg == TW'(EVAL_CYC - 1));
            ev_next = ev_end ? '0 : ev_reg + TW'(1);
            up_seen_next = ev_end ? 1'b0 : (up_seen_reg | s_up_sel); // R23
            dn_seen_next = ev_end ? 1'b0 : (dn_seen_reg | s_dn); // R23
            rs_seen_next = ev_end ? 1'b0 : (rs_seen_reg | s_rst); // R23
            if (ev_end) begin // R5
                if (rs_seen_reg || s_rst) begin
                    val_next = qrvs_pkg::VALLEY_MIN; // R9
                end else if (dn_seen_reg || s_dn) begin
                    if (val_reg != qrvs_pkg::VALLEY_MIN) val_next = val_reg - 3'h1; // R8 R10
                end else if (up_seen_reg || s_up_sel) begin
                    val_next = val_reg; // R7
                end else if (val_reg != qrvs_pkg::VALLEY_MAX) begin
                    val_next = val_reg + 3'h1; // R6 R10
                end
            end
        end
        if (s_bexit) val_next = qrvs_pkg::VALLEY_MIN; // R21
        case (st_reg)
            QRVS_IDLE: begin
                if (s_sup) begin // R1
                    chg_next = 1'b0;
                    st_next = QRVS_ON;
                    gate_next = 1'b1;
                    zc_next = qrvs_pkg::CROSS_MIN; // R15
                    tmr_next = '0;
                end
            end
            QRVS_ON: begin
                tmr_next = tmr_reg + TW'(1);
                if (s_trip && tmr_reg >= TW'(LEB_CYC - 1)) begin // R20
                    st_next = QRVS_OFF;
                    gate_next = 1'b0;
                    tmr_next = '0;
                    ring_next = '0;
                    ovp_next = '0;
                    ring_long_next = !s_ring; // R17
                end
            end
            QRVS_OFF: begin
                tmr_next = tmr_reg + TW'(1);
                if (fall && zc_reg != qrvs_pkg::CROSS_MAX) zc_next = zc_reg + 3'h1; // R13 R14
                if (ring_reg != ring_len(ring_long_reg)) begin
                    ring_next = ring_reg + TW'(1); // R17
                end
                ovp_next = s_ovp ? ovp_reg + TW'(1) : '0;
                if (s_ovp && ovp_reg >= TW'(OVP_BLANK_CYC - 1)) begin // R16
                    st_next = QRVS_LATCH;
                    lat_next = 1'b1;
                end else if (tmr_reg >= TW'(MAX_OFF_CYC - 1) // R19
                    || (ring_reg == ring_len(ring_long_reg)
                        && zc_reg >= val_reg)) begin // R4 R18
                    st_next = QRVS_ON;
                    gate_next = 1'b1;
                    zc_next = qrvs_pkg::CROSS_MIN; // R15
                    tmr_next = '0;
                end
            end
            QRVS_LATCH: begin
                gate_next = 1'b0; // R16
            end
            default: st_next = QRVS_IDLE;
        endcase
    end

    // =====================================================================
    // registers, frozen while clock enable is low
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            st_reg <= QRVS_IDLE;
            tmr_reg <= '0;
            ss_reg <= '0;
            step_reg <= 2'h0;
            ss_done_reg <= 1'b0;
            ev_reg <= '0;
            up_seen_reg <= 1'b0;
            dn_seen_reg <= 1'b0;
            rs_seen_reg <= 1'b0;
            val_reg <= qrvs_pkg::VALLEY_MIN; // R11
            zc_reg <= qrvs_pkg::CROSS_MIN;
            cross_d_reg <= 1'b0;
            ring_reg <= '0;
            ring_long_reg <= 1'b1;
            ovp_reg <= '0;
            gate_reg <= 1'b0;
            chg_reg <= 1'b1;
            lat_reg <= 1'b0;
            ceil_reg <= qrvs_pkg::CEIL_FIRST_MV;
        end else if (ce_i) begin
            st_reg <= st_next;
            tmr_reg <= tmr_next;
            ss_reg <= ss_next;
            step_reg <= step_next;
            ss_done_reg <= ss_done_next;
            ev_reg <= ev_next;
            up_seen_reg <= up_seen_next;
            dn_seen_reg <= dn_seen_next;
            rs_seen_reg <= rs_seen_next;
            val_reg <= val_next;
            zc_reg <= zc_next;
            cross_d_reg <= cross_d_next;
            ring_reg <= ring_next;
            ring_long_reg <= ring_long_next;
            ovp_reg <= ovp_next;
            gate_reg <= gate_next;
            chg_reg <= chg_next;
            lat_reg <= lat_next;
            ceil_reg <= ceil_next;
        end
    end

    assign charge_en_o = chg_reg;
    assign gate_o = gate_reg;
    assign latched_off_o = lat_reg;
    assign soft_done_o = ss_done_reg;
    assign ceiling_mv_o = ceil_reg;
    assign valley_o = val_reg;
    assign cross_cnt_o = zc_reg;

    // =====================================================================
    // checks
    valley_range_a: assert property (@(posedge mclk_i) disable iff (rst_i) // R10
        val_reg >= qrvs_pkg::VALLEY_MIN && val_reg <= qrvs_pkg::VALLEY_MAX)
        else $error("valley count out of range");
    reset_force_a: assert property (@(posedge mclk_i) disable iff (rst_i) // R9
        (ce_i && st_reg == QRVS_OFF && ev_reg == TW'(EVAL_CYC - 1) && rs_seen_reg) |=> val_reg == 3'h1)
        else $error("reset threshold did not force one");
    burst_exit_a: assert property (@(posedge mclk_i) disable iff (rst_i) // R21
        (ce_i && s_bexit) |=> val_reg == 3'h1)
        else $error("burst exit did not force one");
    gate_clear_a: assert property (@(posedge mclk_i) disable iff (rst_i) // R15
        $rose(gate_reg) |-> zc_reg == 3'h0)
        else $error("crossing count not cleared at turn-on");
    blank_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i) // R20
        (gate_reg && tmr_reg < TW'(LEB_CYC - 1)) |=> gate_reg)
        else $error("gate dropped inside blanking");
    ring_wait_a: assert property (@(posedge mclk_i) disable iff (rst_i) // R18
        (st_reg == QRVS_OFF && gate_next && tmr_reg < TW'(MAX_OFF_CYC - 1))
        |-> ring_reg == ring_len(ring_long_reg) && zc_reg >= val_reg)
        else $error("turn-on before ring time or valley");
    latch_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i) // R16
        lat_reg |=> lat_reg && !gate_reg)
        else $error("latch-off released");
    startup_a: assert property (@(posedge mclk_i) disable iff (rst_i) // R1
        $fell(chg_reg) |-> gate_reg && ceil_reg == qrvs_pkg::CEIL_FIRST_MV)
        else $error("start without soft-start");
endmodule : qrvs_core

// File: src/qrvs_pkg.sv
// package of constants for the quasi-resonant valley switch timing core
package qrvs_pkg;
    // =====================================================================
    // clock
    localparam int CLK_HZ = 20_000_000;
    localparam int CLK_NS = 50;
    // =====================================================================
    // soft-start
    localparam int SS_TOTAL_MS = 12;
    localparam int SS_STEPS = 4;
    localparam int SS_STEP_CYCLES = (SS_TOTAL_MS * (CLK_HZ / 1000)) / SS_STEPS;
    // ceiling codes in millivolts, first and last
    localparam logic [9:0] CEIL_FIRST_MV = 10'h140; // 0.32 V
    localparam logic [9:0] CEIL_LAST_MV = 10'h3e8;  // 1 V
    localparam logic [9:0] CEIL_STEP_MV = 10'h0e4;  // 228 mV per middle step, last step snaps to 1 V
    // =====================================================================
    // valley counter
    localparam int EVAL_MS = 48;
    localparam int EVAL_CYCLES = EVAL_MS * (CLK_HZ / 1000);
    localparam logic [2:0] VALLEY_MIN = 3'h1;
    localparam logic [2:0] VALLEY_MAX = 3'h7;
    localparam logic [2:0] CROSS_MIN = 3'h0;
    localparam logic [2:0] CROSS_MAX = 3'h7;
    // =====================================================================
    // off-time and blanking timers, plain defaults in ns
    localparam int RING_LONG_NS = 5000;
    localparam int RING_SHORT_NS = 2500;
    localparam int RING_LONG_CYCLES = RING_LONG_NS / CLK_NS;
    localparam int RING_SHORT_CYCLES = RING_SHORT_NS / CLK_NS;
    localparam int MAX_OFF_NS = 50000;
    localparam int MAX_OFF_CYCLES = MAX_OFF_NS / CLK_NS;
    localparam int LEB_NS = 220;
    localparam int LEB_CYCLES = (LEB_NS + CLK_NS - 1) / CLK_NS;
    localparam int OVP_BLANK_NS = 1000;
    localparam int OVP_BLANK_CYCLES = (OVP_BLANK_NS + CLK_NS - 1) / CLK_NS;
    localparam int TMR_W = 24;
endpackage : qrvs_pkg

// File: src/qrvs_sync.sv
// two-flop synchroniser for a bus of comparator outputs
`timescale 1ns/1ps
module qrvs_sync #(
    parameter int W = 8
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] meta_next;
    logic [W-1:0] sync_reg;
    logic [W-1:0] sync_next;

    // =====================================================================
    // next values: first stage feeds only the second
    always_comb begin
        meta_next = ce_i ? async_i : meta_reg;
        sync_next = ce_i ? meta_reg : sync_reg;
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign sync_o = sync_reg;
endmodule : qrvs_sync

// File: testbench/qrvs_far_model.sv
// far-side model: auxiliary winding sense and feedback comparators
`timescale 1ns/1ps
module qrvs_far_model (
    input wire logic mclk_i,
    input wire logic gate_i,
    input wire logic [1:0] fb_lvl_i,
    input wire logic line_high_i,
    input wire logic ring_hi_i,
    input wire logic ovp_i,
    input wire logic damped_i,
    output logic fb_up_lo_o,
    output logic fb_up_hi_o,
    output logic fb_dn_lo_o,
    output logic fb_dn_hi_o,
    output logic fb_rst_o,
    output logic cross_o,
    output logic cross_ring_o,
    output logic cross_ovp_o,
    output logic cur_trip_o
);
    logic [6:0] k = 7'h00;
    // ringing phase restarts at every turn-off and dies out after nine swings
    always @(negedge mclk_i) begin
        k <= gate_i ? 7'h00 : ((k == 7'h48) ? k : k + 7'h01);
    end
    // only the selected pair is truthful, the other reads far above so a wrong pick shows
    assign fb_up_lo_o = line_high_i | (fb_lvl_i >= 2'h1);
    assign fb_dn_lo_o = line_high_i | (fb_lvl_i >= 2'h2);
    assign fb_up_hi_o = ~line_high_i | (fb_lvl_i >= 2'h1);
    assign fb_dn_hi_o = ~line_high_i | (fb_lvl_i >= 2'h2);
    assign fb_rst_o = (fb_lvl_i == 2'h3);
    // sense is clamped low while on; the trip is immediate to lean on blanking
    assign cross_o = ~gate_i & ~damped_i & (k != 7'h48) & ~k[2];
    assign cross_ring_o = ring_hi_i;
    assign cross_ovp_o = ovp_i & ~gate_i;
    assign cur_trip_o = gate_i;
endmodule : qrvs_far_model

// File: testbench/quasi_resonant_valley_switch_timing_test.sv
// self-checking bench for the valley switch timing core
`timescale 1ns/1ps
module quasi_resonant_valley_switch_timing_test;
    // ==========================================================
    // shortened counts, expectations derive from these
    localparam int EV = 100;
    localparam int SS = 20;
    localparam int RL = 30;
    localparam int RS = 6;
    localparam int MO = 200;
    localparam int LB = 5;
    localparam int OB = 20;
    typedef struct packed {logic [1:0] fb; logic lh; logic [2:0] v;} qrvs_row_t;
    logic mclk_i;
    logic rst_i = 1'b1;
    logic ce = 1'b1;
    logic sup = 1'b0, lh = 1'b0, rh = 1'b0, ovp = 1'b0, dmp = 1'b0, bex = 1'b0;
    logic [1:0] fbl = 2'h0;
    logic ul, uh, dl, dh, fr, cr, co, cg, ct, chg, gate, lat, sdn;
    logic [9:0] ceil;
    logic [2:0] vly, xc;
    logic gq = 1'b0, rq = 1'b0, arm = 1'b0;
    logic [2:0] xq = 3'h0;
    int miscompares = 0;
    int n_checks = 0;
    int k, onk = 0, offk = 0;
    logic [9:0] steps [3] = '{10'h224, 10'h308, 10'h3e8};
    // feedback level, line pair, valley after two periods
    qrvs_row_t rows [12] = '{'{2'h0, 1'b0, 3'h4}, '{2'h1, 1'b0, 3'h4}, '{2'h0, 1'b1, 3'h5},
        '{2'h0, 1'b1, 3'h7}, '{2'h0, 1'b0, 3'h7}, '{2'h2, 1'b0, 3'h5}, '{2'h2, 1'b1, 3'h3},
        '{2'h2, 1'b0, 3'h1}, '{2'h2, 1'b0, 3'h1}, '{2'h0, 1'b0, 3'h2}, '{2'h0, 1'b0, 3'h4},
        '{2'h3, 1'b0, 3'h1}};

    qrvs_core #(.SS_STEP_CYC(SS), .EVAL_CYC(EV), .RING_LONG_CYC(RL), .RING_SHORT_CYC(RS),
        .MAX_OFF_CYC(MO), .LEB_CYC(LB), .OVP_BLANK_CYC(OB)) uut (
        .mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce), .supply_on_i(sup), .fb_up_lo_i(ul),
        .fb_up_hi_i(uh), .fb_dn_lo_i(dl), .fb_dn_hi_i(dh), .fb_rst_i(fr), .line_high_i(lh),
        .cross_i(cr), .cross_ovp_i(co), .cross_ring_i(cg), .cur_trip_i(ct), .burst_exit_i(bex),
        .charge_en_o(chg), .gate_o(gate), .latched_off_o(lat), .soft_done_o(sdn),
        .ceiling_mv_o(ceil), .valley_o(vly), .cross_cnt_o(xc));
    qrvs_far_model far (
        .mclk_i(mclk_i), .gate_i(gate), .fb_lvl_i(fbl), .line_high_i(lh), .ring_hi_i(rh),
        .ovp_i(ovp), .damped_i(dmp), .fb_up_lo_o(ul), .fb_up_hi_o(uh), .fb_dn_lo_o(dl),
        .fb_dn_hi_o(dh), .fb_rst_o(fr), .cross_o(cr), .cross_ring_o(cg), .cross_ovp_o(co),
        .cur_trip_o(ct));

    // ==========================================================
    // compare and wait helpers
    task automatic check_bit(input logic got, input logic exp, input string what);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t %s: got %b", $time, what, got);
        end
    endtask : check_bit
    task automatic check_vec(input logic [9:0] got, input logic [9:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t %s: got %h want %h", $time, what, got, exp);
        end
    endtask : check_vec
    task automatic check_span(input int got, input int lo, input int hi, input string what);
        n_checks++;
        if (got < lo || got > hi) begin
            miscompares++;
            $display("[FAIL] %0t %s: %0d cycles", $time, what, got);
        end
    endtask : check_span
    task automatic wait_lvl(ref logic s, input logic v, input int lim, output int n);
        n = 0;
        while (s !== v && n < lim) begin
            @(negedge mclk_i);
            n++;
        end
        if (s !== v) begin
            miscompares++;
            $display("[FAIL] %0t wait ran out", $time);
        end
    endtask : wait_lvl
    task automatic chk_rst();
        check_bit(chg, 1'b1, "charge cell");
        check_bit(gate, 1'b0, "gate");
        check_bit(lat, 1'b0, "latch");
        check_bit(sdn, 1'b0, "soft done");
        check_vec(ceil, 10'h140, "first ceiling");
        check_vec({7'h00, vly}, 10'h001, "valley start");
        check_vec({7'h00, xc}, 10'h000, "crossings start");
    endtask : chk_rst
    task automatic end_of_test();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test

    // ==========================================================
    // clock and hang guard, about four times the planned run
    initial begin
        mclk_i = 1'b0;
        forever #25 mclk_i = ~mclk_i;
    end
    initial begin
        repeat (20000) @(posedge mclk_i);
        miscompares++;
        end_of_test();
    end

    // every switching cycle: on-time, off-time and crossing count at turn-on
    always @(negedge mclk_i) begin
        if (rst_i) begin
            arm = 1'b0;
        end else if (gate && !gq) begin
            if (arm) begin
                check_bit(xq >= vly || offk >= MO - 1, 1'b1, "early turn-on");
                check_bit(offk >= (rq ? RS : RL) - 1, 1'b1, "ring time cut");
                if (rq && vly == 3'h1 && !dmp) check_bit(offk < RL, 1'b1, "short ring unused");
                if (dmp) check_span(offk, MO - 1, MO + 3, "max off");
            end
            onk = 0;
        end else if (!gate && gq) begin
            check_bit(onk >= LB, 1'b1, "blanking cut");
            arm = 1'b1;
            rq = rh;
            offk = 0;
        end else if (gate && onk == 1) begin
            check_vec({7'h00, xc}, 10'h000, "crossings kept");
        end
        gq = gate;
        xq = xc;
        if (gate) onk++;
        else offk++;
    end

    // ==========================================================
    // main sequence
    initial begin
        repeat (4) @(negedge mclk_i);
        rst_i = 1'b0;
        chk_rst();
        @(negedge mclk_i);
        sup = 1'b1;
        wait_lvl(chg, 1'b0, 8, k);
        check_span(k, 2, 4, "start delay");
        check_bit(gate, 1'b1, "first turn-on");
        for (int i = 0; i < 3; i++) begin
            k = 0;
            while (ceil !== steps[i] && k < 2 * SS) begin
                @(negedge mclk_i);
                k++;
            end
            check_vec(ceil, steps[i], "ceiling step");
            check_span(k, SS - 1, SS + 4, "step length");
        end
        wait_lvl(sdn, 1'b1, SS + 6, k);
        check_span(k, SS - 1, SS + 2, "soft end");
        // enable low freezes all state, so no period closes and the gate keeps its level
        ce = 1'b0;
        k = gate;
        repeat (MO) @(negedge mclk_i);
        check_bit(gate, k[0], "frozen gate");
        check_vec({7'h00, vly}, 10'h001, "frozen valley");
        ce = 1'b1;
        // pin valley to 1, then a count-up marks a period boundary
        fbl = 2'h3;
        repeat (2 * EV) @(negedge mclk_i);
        fbl = 2'h0;
        k = 0;
        while (vly === 3'h1 && k < 3 * EV) begin
            @(negedge mclk_i);
            k++;
        end
        repeat (EV / 2) @(negedge mclk_i);
        // each row spans one mixed period then one pure period
        foreach (rows[i]) begin
            fbl = rows[i].fb;
            lh = rows[i].lh;
            repeat (2 * EV) @(negedge mclk_i);
            check_vec({7'h00, vly}, {7'h00, rows[i].v}, "valley");
        end
        // ring select high at turn-off picks the short window; change it only at a fresh
        // turn-on so the whole on-time lets the synchroniser settle before turn-off
        wait_lvl(gate, 1'b0, MO + 10, k);
        wait_lvl(gate, 1'b1, MO + 10, k);
        rh = 1'b1;
        repeat (300) @(negedge mclk_i);
        wait_lvl(gate, 1'b0, MO + 10, k);
        wait_lvl(gate, 1'b1, MO + 10, k);
        rh = 1'b0;
        // burst exit overrides a held count
        fbl = 2'h0;
        repeat (2 * EV) @(negedge mclk_i);
        fbl = 2'h1;
        repeat (4) @(negedge mclk_i);
        check_bit(vly > 3'h1, 1'b1, "valley raised");
        bex = 1'b1;
        @(negedge mclk_i);
        bex = 1'b0;
        repeat (4) @(negedge mclk_i);
        check_vec({7'h00, vly}, 10'h001, "burst exit");
        // no ringing: only the off-time limit restarts the gate; set one cycle into a fresh
        // on-time so the monitor still judges the previous off-time as a ringing one
        wait_lvl(gate, 1'b0, MO + 10, k);
        wait_lvl(gate, 1'b1, MO + 10, k);
        @(negedge mclk_i);
        dmp = 1'b1;
        repeat (3 * MO) @(negedge mclk_i);
        // a short overvoltage is refused, a long one latches for good
        wait_lvl(gate, 1'b0, MO + 10, k);
        ovp = 1'b1;
        repeat (OB / 2) @(negedge mclk_i);
        ovp = 1'b0;
        repeat (OB) @(negedge mclk_i);
        check_bit(lat, 1'b0, "short overvoltage");
        wait_lvl(gate, 1'b1, MO + 10, k);
        wait_lvl(gate, 1'b0, MO + 10, k);
        ovp = 1'b1;
        wait_lvl(lat, 1'b1, OB + 8, k);
        check_span(k, OB, OB + 5, "latch delay");
        ovp = 1'b0;
        repeat (2 * MO) @(negedge mclk_i);
        check_span(offk, 2 * MO, 100000, "gate after latch");
        check_bit(lat, 1'b1, "latch held");
        // second reset in mid-run restores the start values
        rst_i = 1'b1;
        repeat (4) @(negedge mclk_i);
        rst_i = 1'b0;
        chk_rst();
        wait_lvl(chg, 1'b0, 8, k);
        check_span(k, 2, 4, "restart delay");
        end_of_test();
    end
endmodule : quasi_resonant_valley_switch_timing_test
